// >>> src/sswc_pkg.sv
// Purpose: Shared constants and types for the sleep-state and wake controller.
// Assumes: A single always-on standby clock at 40 MHz.
// Notes:   All widths and counts are fixed; long counts are overridable at the top.
//
// Overview of operation
// - After AC returns, go to S0 or S5 per restore_mode; RESTORE_LAST picks by the pre-loss on/off state.
// - Fans on in S0 and S1.
// - Fans off in off, S3, S4, S5.
// - Each fan has tachometer closed-loop speed control.
// - Network wake via WAKE#, PME# or onboard LAN.
// - Modem ring wakes from S1 or S3.
// - Ring wakes only when modem interrupt unmasked.
// - USB activity wakes from S1 or S3.
// - PS/2 activity wakes from S1 or S3.
// - PME# wakes S1 to S5 when enabled.
// - WAKE# wakes S1 to S5, unqualified.
// - S3: supply off, LED amber or dark.
// - Permitted wake in S3 returns to working.
// - S5 wake via LAN or PME# off by default.
package sswc_pkg;

    localparam int unsigned CLK_FREQ_HZ    = 40_000_000;
    localparam int unsigned TACH_WIN_MS    = 250;
    localparam int unsigned TACH_WIN_CYC   = (CLK_FREQ_HZ / 1000) * TACH_WIN_MS;
    localparam int unsigned PWM_FREQ_HZ    = 25_000;
    localparam int unsigned PWM_PERIOD_CYC = CLK_FREQ_HZ / PWM_FREQ_HZ;
    localparam int unsigned PWM_STEPS      = 64;
    localparam int unsigned PWM_STEP_CYC   = PWM_PERIOD_CYC / PWM_STEPS;

    localparam int unsigned NUM_FANS     = 3;
    localparam int unsigned NUM_WAKE     = 7;
    localparam int unsigned WIN_W        = 24;
    localparam int unsigned PRE_W        = 5;

    localparam logic [6:0] DUTY_FULL     = 7'h40;
    localparam logic [6:0] DUTY_RST      = 7'h40;
    localparam logic [7:0] TACH_MAX      = 8'hFF;
    localparam logic [7:0] TACH_RST      = 8'h00;
    localparam logic       LAST_ON_RST   = 1'b0;

    // Gray coded along the usual path S0 -> S1 -> S3 -> S4 -> S5 -> mechanical off.
    typedef enum logic [2:0] {
        PS_S0 = 3'h0,
        PS_S1 = 3'h1,
        PS_S3 = 3'h3,
        PS_S4 = 3'h2,
        PS_S5 = 3'h6,
        PS_G3 = 3'h7
    } sswc_pstate_t;

    localparam sswc_pstate_t PS_RST = PS_G3;

    typedef enum logic [1:0] {
        RESTORE_OFF  = 2'h0,
        RESTORE_ON   = 2'h1,
        RESTORE_LAST = 2'h2
    } sswc_restore_t;

    typedef enum logic [1:0] {
        FAN_AUTO = 2'h0,
        FAN_FULL = 2'h1,
        FAN_STOP = 2'h2
    } sswc_fan_mode_t;

    typedef struct packed {
        logic lan_wake;
        logic pme_n;
        logic pcie_wake_n;
        logic ring;
        logic usb_act;
        logic ps2_act;
        logic pwr_btn;
    } sswc_wake_t;

    typedef struct packed {
        logic pme_en;
        logic lan_s5_en;
        logic pme_s5_en;
        logic modem_irq_unmask;
    } sswc_wake_cfg_t;

    typedef struct packed {
        logic         valid;
        sswc_pstate_t target;
    } sswc_cmd_t;

    typedef struct packed {
        sswc_fan_mode_t mode;
        logic [7:0]     target;
    } sswc_fan_cfg_t;

    typedef struct packed {
        logic       pwr;
        logic       pwm;
        logic [7:0] tach_meas;
    } sswc_fan_stat_t;

endpackage

// >>> src/sswc_fan_chan.sv
// Purpose: One fan channel with on/off switch, PWM drive and tachometer loop.
// Assumes: Tachometer pulses are synchronous to mclk.
// Notes:   The loop moves duty by one step per measuring window.
`timescale 1ns/1ps
module sswc_fan_chan #(
    parameter int unsigned WIN_CYC = sswc_pkg::TACH_WIN_CYC
) (
    input  wire logic                    mclk,
    input  wire logic                    sys_rst,
    input  wire logic                    fan_en,
    input  wire logic                    tach,
    input  wire sswc_pkg::sswc_fan_cfg_t cfg,
    output sswc_pkg::sswc_fan_stat_t     stat
);

    logic [6:0]                    duty_ff;
    logic [5:0]                    step_ff;
    logic [sswc_pkg::PRE_W-1:0]    pre_ff;
    logic [sswc_pkg::WIN_W-1:0]    win_ff;
    logic [7:0]                    tcnt_ff;
    logic [7:0]                    meas_ff;
    logic                          tach_d_ff;
    logic                          pwr_ff;
    logic                          pwm_ff;

    wire pre_end  = (pre_ff == sswc_pkg::PRE_W'(sswc_pkg::PWM_STEP_CYC - 1));
    wire win_end  = (win_ff == sswc_pkg::WIN_W'(WIN_CYC - 1));
    wire tach_re  = tach & ~tach_d_ff;
    wire tcnt_sat = (tcnt_ff == sswc_pkg::TACH_MAX);
    wire too_slow = (meas_ff < cfg.target) && (duty_ff != sswc_pkg::DUTY_FULL);
    wire too_fast = (meas_ff > cfg.target) && (duty_ff != 7'h00);

    // Forced modes override the loop; the loop keeps its duty so AUTO resumes smoothly.
    wire [6:0] eff_duty = (cfg.mode == sswc_pkg::FAN_FULL) ? sswc_pkg::DUTY_FULL :
                          (cfg.mode == sswc_pkg::FAN_STOP) ? 7'h00 : duty_ff;
    wire       nxt_pwr  = fan_en && (eff_duty != 7'h00);
    wire       nxt_pwm  = nxt_pwr && ({1'b0, step_ff} < eff_duty);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_ff  <= '0;
            step_ff <= '0;
            win_ff  <= '0;
        end else begin
            pre_ff  <= pre_end ? '0 : pre_ff + 1'b1;
            step_ff <= pre_end ? step_ff + 1'b1 : step_ff;
            win_ff  <= win_end ? '0 : win_ff + 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tach_d_ff <= 1'b0;
            tcnt_ff   <= sswc_pkg::TACH_RST;
            meas_ff   <= sswc_pkg::TACH_RST;
        end else begin
            tach_d_ff <= tach;
            if (win_end) begin
                tcnt_ff <= sswc_pkg::TACH_RST;
                meas_ff <= tcnt_ff;
            end else if (tach_re && !tcnt_sat) begin
                tcnt_ff <= tcnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            duty_ff <= sswc_pkg::DUTY_RST;
        end else if (win_end && fan_en && cfg.mode == sswc_pkg::FAN_AUTO) begin
            if (too_slow) begin
                duty_ff <= duty_ff + 1'b1;
            end else if (too_fast) begin
                duty_ff <= duty_ff - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pwr_ff <= 1'b0;
            pwm_ff <= 1'b0;
        end else begin
            pwr_ff <= nxt_pwr;
            pwm_ff <= nxt_pwm;
        end
    end

    assign stat.pwr       = pwr_ff;
    assign stat.pwm       = pwm_ff;
    assign stat.tach_meas = meas_ff;

endmodule

// >>> src/sswc_top.sv
// Purpose: Sleep-state tracking, wake qualification, AC-loss restore and fan switching.
// Assumes: Runs from standby power; inputs other than wake sources are synchronous.
// Notes:   A wake always returns to S0; sleep commands are taken only in S0.
`timescale 1ns/1ps
module sswc_top #(
    parameter int unsigned TACH_WIN_CYC = sswc_pkg::TACH_WIN_CYC
) (
    input  wire logic                                        mclk,
    input  wire logic                                        sys_rst,
    input  wire logic                                        ac_ok,
    input  wire sswc_pkg::sswc_restore_t                     restore_mode,
    input  wire sswc_pkg::sswc_cmd_t                         sleep_cmd,
    input  wire sswc_pkg::sswc_wake_t                        wake_in,
    input  wire sswc_pkg::sswc_wake_cfg_t                    wake_cfg,
    input  wire logic                                        wake_src_clr,
    input  wire logic                                        led_dual,
    input  wire logic [sswc_pkg::NUM_FANS-1:0]               fan_tach,
    input  wire sswc_pkg::sswc_fan_cfg_t [sswc_pkg::NUM_FANS-1:0] fan_cfg,
    output sswc_pkg::sswc_pstate_t                           pstate,
    output logic                                             ps_on,
    output logic                                             led_main,
    output logic                                             led_amber,
    output logic                                             wake_req,
    output logic [sswc_pkg::NUM_WAKE-1:0]                    wake_src,
    output sswc_pkg::sswc_fan_stat_t [sswc_pkg::NUM_FANS-1:0] fan_stat
);

    sswc_pkg::sswc_pstate_t         ps_ff;
    sswc_pkg::sswc_pstate_t         nxt_ps;
    sswc_pkg::sswc_wake_t           wake_act;
    sswc_pkg::sswc_wake_t           wake_meta_ff;
    sswc_pkg::sswc_wake_t           wake_sync_ff;
    sswc_pkg::sswc_wake_t           wake_ok;
    logic                           last_on_ff;
    logic                           ps_on_ff;
    logic                           led_main_ff;
    logic                           led_amber_ff;
    logic                           wake_req_ff;
    logic [sswc_pkg::NUM_WAKE-1:0]  wake_src_ff;
    logic                           nxt_last_on;

    // Active-low lines are flipped ahead of the synchroniser so every source
    // reads active high afterwards; the inversion sits before the first flop.
    assign wake_act.lan_wake    = wake_in.lan_wake;
    assign wake_act.pme_n       = ~wake_in.pme_n;
    assign wake_act.pcie_wake_n = ~wake_in.pcie_wake_n;
    assign wake_act.ring        = wake_in.ring;
    assign wake_act.usb_act     = wake_in.usb_act;
    assign wake_act.ps2_act     = wake_in.ps2_act;
    assign wake_act.pwr_btn     = wake_in.pwr_btn;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wake_meta_ff <= '0;
            wake_sync_ff <= '0;
        end else begin
            wake_meta_ff <= wake_act;
            wake_sync_ff <= wake_meta_ff;
        end
    end

    // State decodes.
    wire in_s0    = (ps_ff == sswc_pkg::PS_S0);
    wire in_s1    = (ps_ff == sswc_pkg::PS_S1);
    wire in_s3    = (ps_ff == sswc_pkg::PS_S3);
    wire in_s4    = (ps_ff == sswc_pkg::PS_S4);
    wire in_s5    = (ps_ff == sswc_pkg::PS_S5);
    wire in_g3    = (ps_ff == sswc_pkg::PS_G3);
    wire in_s13   = in_s1 | in_s3;
    wire in_s134  = in_s13 | in_s4;
    wire in_sleep = in_s134 | in_s5;

    // Each source is qualified by the states it may wake from; LAN, PME# and ring are also qualified by their enables.
    // The onboard LAN is one network path; the others reach us as PME# and WAKE#.
    assign wake_ok.lan_wake    = wake_sync_ff.lan_wake &
                                 (in_s134 | (in_s5 & wake_cfg.lan_s5_en));
    assign wake_ok.pme_n       = wake_sync_ff.pme_n & wake_cfg.pme_en &
                                 (in_s134 | (in_s5 & wake_cfg.pme_s5_en));
    assign wake_ok.pcie_wake_n = wake_sync_ff.pcie_wake_n & in_sleep;
    assign wake_ok.ring        = wake_sync_ff.ring & wake_cfg.modem_irq_unmask &
                                 in_s13;
    assign wake_ok.usb_act     = wake_sync_ff.usb_act & in_s13;
    assign wake_ok.ps2_act     = wake_sync_ff.ps2_act & in_s13;
    assign wake_ok.pwr_btn     = wake_sync_ff.pwr_btn & in_sleep;

    wire any_wake = |wake_ok;

    // A sleep command names the target; anything other than a sleep state is ignored.
    wire cmd_sleep = sleep_cmd.valid &&
                     (sleep_cmd.target == sswc_pkg::PS_S1 ||
                      sleep_cmd.target == sswc_pkg::PS_S3 ||
                      sleep_cmd.target == sswc_pkg::PS_S4 ||
                      sleep_cmd.target == sswc_pkg::PS_S5);

    // Power restore choice after a mechanical-off period.
    wire restore_on = (restore_mode == sswc_pkg::RESTORE_ON) ||
                      ((restore_mode == sswc_pkg::RESTORE_LAST) && last_on_ff);

    always_comb begin
        nxt_ps = ps_ff;
        case (ps_ff)
            sswc_pkg::PS_S0: begin
                if (cmd_sleep) begin
                    nxt_ps = sleep_cmd.target;
                end
            end
            sswc_pkg::PS_S1,
            sswc_pkg::PS_S3,
            sswc_pkg::PS_S4,
            sswc_pkg::PS_S5: begin
                if (any_wake) begin
                    nxt_ps = sswc_pkg::PS_S0;
                end
            end
            sswc_pkg::PS_G3: begin
                nxt_ps = restore_on ? sswc_pkg::PS_S0 : sswc_pkg::PS_S5;
            end
            default: begin
                nxt_ps = sswc_pkg::PS_G3;
            end
        endcase
        // Losing AC overrides everything and waits for power to return.
        if (!ac_ok) begin
            nxt_ps = sswc_pkg::PS_G3;
        end
    end

    // Remember on or off while AC is good; during the loss the value is frozen.
    // Any state other than soft-off counts as on, since its context is gone anyway.
    assign nxt_last_on = (ac_ok && !in_g3) ? !in_s5 : last_on_ff;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ps_ff      <= sswc_pkg::PS_RST;
            last_on_ff <= sswc_pkg::LAST_ON_RST;
        end else begin
            ps_ff      <= nxt_ps;
            last_on_ff <= nxt_last_on;
        end
    end

    // Outputs follow the state being entered so they line up with pstate.
    wire nxt_run      = (nxt_ps == sswc_pkg::PS_S0) || (nxt_ps == sswc_pkg::PS_S1);
    wire nxt_s3       = (nxt_ps == sswc_pkg::PS_S3);
    wire nxt_led_main = nxt_run;
    wire nxt_led_amb  = nxt_s3 & led_dual;
    wire nxt_wake     = any_wake & in_sleep & ac_ok;

    // The main supply is off in every sleep state except S1; the supply itself
    // keeps standby only, which we rely on when ps_on drops.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ps_on_ff     <= 1'b0;
            led_main_ff  <= 1'b0;
            led_amber_ff <= 1'b0;
            wake_req_ff  <= 1'b0;
        end else begin
            ps_on_ff     <= nxt_run;
            led_main_ff  <= nxt_led_main;
            led_amber_ff <= nxt_led_amb;
            wake_req_ff  <= nxt_wake;
        end
    end

    // Sticky record of which sources woke the system; a new wake beats a clear.
    wire [sswc_pkg::NUM_WAKE-1:0] wake_hit = nxt_wake ? wake_ok : '0;
    wire [sswc_pkg::NUM_WAKE-1:0] nxt_src  = (wake_src_clr ? '0 : wake_src_ff) | wake_hit;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wake_src_ff <= '0;
        end else begin
            wake_src_ff <= nxt_src;
        end
    end

    // Fans are switched by the state; speed inside S0/S1 is each channel's own loop.
    wire fan_run = in_s0 | in_s1;

    for (genvar i = 0; i < sswc_pkg::NUM_FANS; i++) begin : g_fan
        sswc_fan_chan #(
            .WIN_CYC (TACH_WIN_CYC)
        ) u_fan (
            .mclk    (mclk),
            .sys_rst (sys_rst),
            .fan_en  (fan_run),
            .tach    (fan_tach[i]),
            .cfg     (fan_cfg[i]),
            .stat    (fan_stat[i])
        );
    end

    assign pstate    = ps_ff;
    assign ps_on     = ps_on_ff;
    assign led_main  = led_main_ff;
    assign led_amber = led_amber_ff;
    assign wake_req  = wake_req_ff;
    assign wake_src  = wake_src_ff;

endmodule

// >>> tb/sswc_top_chk.sv
// Purpose: Port-level checks for the sleep-state and wake controller.
// Assumes: wake_cfg and led_dual only change while the system is working.
// Notes:   A wake takes two synchroniser stages plus the state register.
`timescale 1ns/1ps
module sswc_top_chk #(
    parameter int unsigned TACH_WIN_CYC = 64
) (
    input wire logic                                              mclk,
    input wire logic                                              sys_rst,
    input wire logic                                              ac_ok,
    input wire sswc_pkg::sswc_restore_t                           restore_mode,
    input wire sswc_pkg::sswc_cmd_t                               sleep_cmd,
    input wire sswc_pkg::sswc_wake_t                              wake_in,
    input wire sswc_pkg::sswc_wake_cfg_t                          wake_cfg,
    input wire logic                                              wake_src_clr,
    input wire logic                                              led_dual,
    input wire logic [sswc_pkg::NUM_FANS-1:0]                     fan_tach,
    input wire sswc_pkg::sswc_fan_cfg_t [sswc_pkg::NUM_FANS-1:0]  fan_cfg,
    input wire sswc_pkg::sswc_pstate_t                            pstate,
    input wire logic                                              ps_on,
    input wire logic                                              led_main,
    input wire logic                                              led_amber,
    input wire logic                                              wake_req,
    input wire logic [sswc_pkg::NUM_WAKE-1:0]                     wake_src,
    input wire sswc_pkg::sswc_fan_stat_t [sswc_pkg::NUM_FANS-1:0] fan_stat
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    logic on_st, low, slp, fan_any, ok_now, g3_up;
    assign on_st   = pstate inside {sswc_pkg::PS_S0, sswc_pkg::PS_S1};
    assign low     = pstate inside {sswc_pkg::PS_S1, sswc_pkg::PS_S3};
    assign slp     = low || pstate inside {sswc_pkg::PS_S4, sswc_pkg::PS_S5};
    assign fan_any = fan_stat[0].pwr || fan_stat[1].pwr || fan_stat[2].pwr;
    assign g3_up   = pstate == sswc_pkg::PS_G3 && ac_ok;
    // A source counts only if it may wake the present state with the present settings.
    assign ok_now  = slp && (wake_in.pwr_btn || !wake_in.pcie_wake_n
                     || (wake_in.lan_wake && (pstate != sswc_pkg::PS_S5 || wake_cfg.lan_s5_en))
                     || (!wake_in.pme_n && wake_cfg.pme_en && (pstate != sswc_pkg::PS_S5 || wake_cfg.pme_s5_en))
                     || (low && (wake_in.usb_act || wake_in.ps2_act || (wake_in.ring && wake_cfg.modem_irq_unmask))));

    fan_off_a: assert property (!on_st |=> !fan_any)
        else $error("fan powered outside the working states");
    fan_on_a: assert property ((on_st && fan_cfg[0].mode == sswc_pkg::FAN_FULL) [*3] |=> fan_stat[0].pwr)
        else $error("full-speed fan not powered while working");
    supply_a: assert property (ps_on == on_st && led_main == on_st)
        else $error("main supply or main lamp disagrees with state");
    amber_a: assert property ($stable(led_dual) |-> led_amber == (pstate == sswc_pkg::PS_S3 && led_dual))
        else $error("amber lamp wrong for state");
    wake_a: assert property ((slp && ok_now && ac_ok) [*3] |=> pstate == sswc_pkg::PS_S0)
        else $error("permitted wake did not return to working");
    hold_a: assert property ((slp && !ok_now && ac_ok) [*4] ##1 ac_ok |-> pstate == $past(pstate))
        else $error("sleep state left without permitted wake");
    pulse_a: assert property (wake_req == (pstate == sswc_pkg::PS_S0 && $past(slp)))
        else $error("wake request pulse does not match wake transition");
    src_a: assert property (wake_req |-> wake_src != '0)
        else $error("wake with no recorded source");
    rest_on_a: assert property (g3_up && restore_mode == sswc_pkg::RESTORE_ON |=> pstate == sswc_pkg::PS_S0)
        else $error("restore-on did not power up");
    rest_off_a: assert property (g3_up && restore_mode == sswc_pkg::RESTORE_OFF |=> pstate == sswc_pkg::PS_S5)
        else $error("restore-off did not stay soft-off");

    cover property (pstate == sswc_pkg::PS_S5 ##1 wake_req);
    cover property (pstate == sswc_pkg::PS_S3 ##1 wake_req);
    cover property (pstate == sswc_pkg::PS_G3 ##1 pstate == sswc_pkg::PS_S5);
endmodule

bind sswc_top sswc_top_chk #(.TACH_WIN_CYC(TACH_WIN_CYC)) i_chk (
    .mclk(mclk), .sys_rst(sys_rst), .ac_ok(ac_ok), .restore_mode(restore_mode), .sleep_cmd(sleep_cmd),
    .wake_in(wake_in), .wake_cfg(wake_cfg), .wake_src_clr(wake_src_clr), .led_dual(led_dual),
    .fan_tach(fan_tach), .fan_cfg(fan_cfg), .pstate(pstate), .ps_on(ps_on), .led_main(led_main),
    .led_amber(led_amber), .wake_req(wake_req), .wake_src(wake_src), .fan_stat(fan_stat)
);

// >>> tb/sswc_far_side.sv
// Purpose: Wake sources and chassis fans as seen from the controller.
// Assumes: Wake lines are pulled to their idle level when no source drives them.
// Notes:   Every running fan gives one tachometer pulse each four cycles.
`timescale 1ns/1ps
module sswc_far_side (
    input  wire logic                                              mclk,
    input  wire logic                                              sys_rst,
    input  wire logic                                              ps_on,
    input  wire sswc_pkg::sswc_fan_stat_t [sswc_pkg::NUM_FANS-1:0] fan_stat,
    input  wire logic                                              wake_go,
    input  wire logic [2:0]                                        wake_pick,
    output sswc_pkg::sswc_wake_t                                   wake_in,
    output logic [sswc_pkg::NUM_FANS-1:0]                          fan_tach
);
    logic [1:0] rot_ff;

    // Only one source asserts at a time; the two active-low lines idle high.
    assign wake_in = sswc_pkg::sswc_wake_t'(7'h30 ^ ({6'h00, wake_go} << wake_pick));

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rot_ff <= 2'h0;
        end else begin
            rot_ff <= rot_ff + 2'h1;
        end
    end

    // Fans hang on the main rail, so a fan only spins while the supply keeps more than standby.
    always_comb begin
        for (int i = 0; i < sswc_pkg::NUM_FANS; i++) begin
            fan_tach[i] = ps_on && fan_stat[i].pwr && rot_ff == 2'h0;
        end
    end
endmodule

// >>> tb/sswc_top_test.sv
// Purpose: Directed bench for the sleep-state and wake controller.
// Assumes: A 64-cycle tachometer window so the fan loop steps its duty many times within the run.
// Notes:   Results are sampled on the falling edge, clear of register updates.
`timescale 1ns/1ps
module sswc_top_test;
    // Each entry is {target, source, wake settings, wakes}, one hex digit apiece.
    localparam logic [15:0] CASES [17] = '{16'h3201, 16'h2200, 16'h1101, 16'h6100, 16'h3311, 16'h3300,
        16'h2310, 16'h6600, 16'h6641, 16'h2601, 16'h3500, 16'h2581, 16'h6580, 16'h65A1, 16'h6401,
        16'h1401, 16'h2001};
    logic                                              mclk;
    logic                                              sys_rst = 1'b1, ac_ok = 1'b1, wake_go = 1'b0;
    logic                                              wake_src_clr = 1'b0, led_dual = 1'b0;
    logic                                              ps_on, led_main, led_amber, wake_req;
    logic [2:0]                                        wake_pick = 3'h0;
    logic [15:0]                                       c;
    sswc_pkg::sswc_restore_t                           restore_mode = sswc_pkg::RESTORE_ON;
    sswc_pkg::sswc_cmd_t                               sleep_cmd = '0;
    sswc_pkg::sswc_wake_t                              wake_in;
    sswc_pkg::sswc_wake_cfg_t                          wake_cfg = '0;
    sswc_pkg::sswc_pstate_t                            pstate;
    logic [sswc_pkg::NUM_FANS-1:0]                     fan_tach;
    logic [sswc_pkg::NUM_WAKE-1:0]                     wake_src;
    sswc_pkg::sswc_fan_cfg_t [sswc_pkg::NUM_FANS-1:0]  fan_cfg = {10'h008, 10'h200, 10'h100};
    sswc_pkg::sswc_fan_stat_t [sswc_pkg::NUM_FANS-1:0] fan_stat;
    int                                                n_errors = 0, n_compared = 0, cyc = 0, n_req, n_low;

    sswc_top #(.TACH_WIN_CYC(64)) i_dut (
        .mclk(mclk), .sys_rst(sys_rst), .ac_ok(ac_ok), .restore_mode(restore_mode), .sleep_cmd(sleep_cmd),
        .wake_in(wake_in), .wake_cfg(wake_cfg), .wake_src_clr(wake_src_clr), .led_dual(led_dual),
        .fan_tach(fan_tach), .fan_cfg(fan_cfg), .pstate(pstate), .ps_on(ps_on), .led_main(led_main),
        .led_amber(led_amber), .wake_req(wake_req), .wake_src(wake_src), .fan_stat(fan_stat)
    );
    sswc_far_side i_far (
        .mclk(mclk), .sys_rst(sys_rst), .ps_on(ps_on), .fan_stat(fan_stat), .wake_go(wake_go),
        .wake_pick(wake_pick), .wake_in(wake_in), .fan_tach(fan_tach)
    );

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic print_verdict();
        if (n_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic sleep(input logic [2:0] t);
        step(1);
        sleep_cmd <= sswc_pkg::sswc_cmd_t'({1'b1, t});
        step(1);
        sleep_cmd <= '0;
        step(2);
        @(negedge mclk);
    endtask

    // Holds the source for six cycles, counting wake pulses, then lets the line go idle.
    task automatic hit(input logic [2:0] pick);
        step(1);
        wake_pick <= pick;
        wake_go   <= 1'b1;
        n_req = 0;
        repeat (6) begin
            @(negedge mclk);
            n_req += (wake_req === 1'b1);
        end
        step(1);
        wake_go <= 1'b0;
        repeat (4) @(negedge mclk);
    endtask

    task automatic ac_cycle(input sswc_pkg::sswc_restore_t m, input logic [2:0] e);
        step(1);
        restore_mode <= m;
        ac_ok        <= 1'b0;
        step(3);
        ac_ok <= 1'b1;
        step(2);
        @(negedge mclk);
        chk_v({5'h00, pstate}, {5'h00, e});
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        step(12);
        sys_rst <= 1'b0;
        step(2);
        @(negedge mclk);
        chk_v({5'h00, pstate}, 8'h00);
        for (int k = 0; k < 17; k++) begin
            c = CASES[k];
            step(1);
            wake_cfg     <= sswc_pkg::sswc_wake_cfg_t'(c[7:4]);
            led_dual     <= k[0];
            wake_src_clr <= 1'b1;
            step(1);
            wake_src_clr <= 1'b0;
            sleep(c[14:12]);
            chk_v({5'h00, pstate}, {5'h00, c[14:12]});
            chk_v({5'h00, ps_on, led_amber, fan_stat[0].pwr},
                  {5'h00, c[14:12] == 3'h1, c[14:12] == 3'h3 && k[0], c[14:12] == 3'h1});
            hit(c[10:8]);
            chk_v(n_req[7:0], {7'h00, c[0]});
            chk_v({5'h00, pstate}, c[0] ? 8'h00 : {5'h00, c[14:12]});
            if (c[0]) begin
                chk_v({1'b0, wake_src}, 8'h01 << c[10:8]);
            end else begin
                hit(3'h0);
            end
            chk_v({7'h00, fan_stat[0].pwr}, 8'h01);
        end
        ac_cycle(sswc_pkg::RESTORE_LAST, 3'h0);
        sleep(3'h6);
        ac_cycle(sswc_pkg::RESTORE_LAST, 3'h6);
        ac_cycle(sswc_pkg::RESTORE_ON, 3'h0);
        ac_cycle(sswc_pkg::RESTORE_OFF, 3'h6);
        hit(3'h0);
        step(400);
        @(negedge mclk);
        chk_v(fan_stat[0].tach_meas, 8'h10);
        chk_v({fan_stat[1].pwr, fan_stat[1].tach_meas[6:0]}, 8'h00);
        n_low = 0;
        repeat (1600) begin
            @(negedge mclk);
            n_low += (fan_stat[2].pwm === 1'b0);
        end
        chk_v({7'h00, n_low != 0}, 8'h01);
        print_verdict();
    end
endmodule
